// ==== shared/lpm_seq_pkg.sv ====
// package for the low-power mode wake-up sequencer: modes, states, counts
// assumes one clock (system clock rate); input clock cycles counted as system cycles
//
// Overview of operation
// - idle wakes on enabled interrupt, watchdog wake, nonmaskable wake pin or reset pin
// - qualification time is five times sample period times two cycles
// - idle resume no sooner than 8 or 1050 cycles, plus qualification
// - latency counts to next instruction after idle; service routine adds more
// - standby entry keeps system clock about 32 cycles before gating
// - standby resume no sooner than 12 or 1125 cycles, plus pulse width
// - after standby, wake interrupt serviced only if enabled
// - halt entry, last external clock edge at least 32 cycles later
// - halt entry gates system clock after 32 cycles, stops oscillator after external clock stops at 45
// - in halt all clocks off, oscillator and pll shut down
// - in halt, nonmaskable wake pin restarts oscillator, pll stays off
// - wake pin release starts pll lock lasting 131072 input cycles
// - after halt lock, resume no sooner than 1125 or 35 cycles
// - halt exits when core clock re-enabled; then service interrupt if enabled
package lpm_seq_pkg;
  typedef enum logic [1:0] {mode_idle, mode_standby, mode_halt, mode_rsvd} lpm_mode_e;
  typedef enum {st_run, st_flush, st_low, st_osc, st_lock, st_resume} lpm_state_e;
  localparam int flush_cycles = 32;
  localparam int halt_flush_cycles = 45;
  localparam int idle_resume_fast = 8;
  localparam int idle_resume_sleep = 1050;
  localparam int stby_resume_fast = 12;
  localparam int stby_resume_sleep = 1125;
  localparam int halt_resume_fast = 35;
  localparam int halt_resume_sleep = 1125;
  localparam int stby_plain_width = 12;
  localparam int stby_qual_base = 2;
  localparam int pll_lock_cycles = 131072;
  localparam int qual_windows = 5;
  localparam int qual_period_mult = 2;
  localparam int cnt_w = 18;
  localparam logic [7:0] qual_period_reset = 8'h00;
  localparam logic [5:0] stby_qual_reset = 6'h00;
endpackage

// ==== logic/wake_qualifier.sv ====
// input qualifier: a synchronised level must hold stable for a time to count
// assumes input already synchronised to core_clk_i
`timescale 1ns/1ns
module wake_qualifier (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic [17:0] hold_cycles_i,
  input wire logic level_i,
  // result
  output logic qualified_o
);
  import lpm_seq_pkg::*;
  typedef struct packed {
    logic [17:0] cnt;
    logic q;
  } qual_s;
  qual_s r, next_r;
  always_comb begin
    next_r = r;
    if (!level_i) begin
      next_r.cnt = '0;
      next_r.q = 1'b0;
    end else if (r.cnt >= hold_cycles_i) begin
      next_r.q = 1'b1;
    end else begin
      next_r.cnt = r.cnt + 18'h0_0001;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign qualified_o = r.q;
endmodule // wake_qualifier

// ==== logic/lpm_wakeup_sequencer.sv ====
// low-power mode entry/exit sequencer: clock gating, oscillator, pll, resume
// assumes core pulses idle_instr_i for one cycle; pins are asynchronous
`timescale 1ns/1ns
module lpm_wakeup_sequencer #(
  parameter int pll_lock_len = lpm_seq_pkg::pll_lock_cycles
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // core side
  input wire logic idle_instr_i,
  input wire lpm_seq_pkg::lpm_mode_e low_power_mode_i,
  input wire logic flash_sleeping_i,
  input wire logic [7:0] qual_sample_period_i,
  input wire logic [5:0] standby_wake_qual_count_i,
  input wire logic qual_enable_i,
  input wire logic wake_int_enable_i,
  // wake sources
  input wire logic enabled_int_i,
  input wire logic watchdog_wake_interrupt_i,
  input wire logic nonmaskable_wake_pin_n_i,
  input wire logic device_reset_pin_n_i,
  // clock control
  output logic system_clock_en_o,
  output logic external_clock_out_en_o,
  output logic core_clock_input_en_o,
  output logic osc_en_o,
  output logic pll_en_o,
  // status to core
  output logic resume_o,
  output logic wake_int_service_o,
  output lpm_seq_pkg::lpm_mode_e active_mode_o
);
  import lpm_seq_pkg::*;
  typedef struct packed {
    logic [1:0] nmi_sync;
    logic [1:0] rst_sync;
    lpm_state_e st;
    lpm_mode_e mode;
    logic [cnt_w-1:0] cnt;
    logic [cnt_w-1:0] wake_cnt;
    logic sys_en;
    logic xclk_en;
    logic core_en;
    logic osc;
    logic pll;
    logic resume;
    logic service;
  } seq_s;
  seq_s r, next_r;
  logic nmi_act, rst_act, nmi_q, rst_q, wake_any;
  logic [cnt_w-1:0] input_qual_time, qual_hold, resume_len;
  assign nmi_act = !r.nmi_sync[1];
  assign rst_act = !r.rst_sync[1];
  // qualification time = 5 x period x 2
  assign input_qual_time = cnt_w'(qual_windows * qual_period_mult) * cnt_w'(qual_sample_period_i);
  // pin filter length: halt wakes on a bare pulse, standby counts input cycles
  always_comb begin
    qual_hold = cnt_w'(1);
    if (!qual_enable_i) begin
      qual_hold = cnt_w'(1);
    end else if (r.mode == mode_halt) begin
      qual_hold = cnt_w'(1);
    end else if (r.mode == mode_standby) begin
      qual_hold = cnt_w'(stby_qual_base) + cnt_w'(standby_wake_qual_count_i);
    end else begin
      qual_hold = input_qual_time + cnt_w'(1);
    end
  end
  wake_qualifier u_nmi_qual (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .hold_cycles_i(qual_hold),
    .level_i(nmi_act),
    .qualified_o(nmi_q)
  );
  wake_qualifier u_rst_qual (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .hold_cycles_i(qual_hold),
    .level_i(rst_act),
    .qualified_o(rst_q)
  );
  // any accepted wake source while idle or standby
  assign wake_any = nmi_q | rst_q | watchdog_wake_interrupt_i | enabled_int_i;
  logic [cnt_w-1:0] resume_base, resume_extra;
  always_comb begin
    resume_base = '0;
    resume_extra = '0;
    case (r.mode)
      mode_idle: begin
        resume_base = flash_sleeping_i ? cnt_w'(idle_resume_sleep) :
          cnt_w'(idle_resume_fast);
        resume_extra = qual_enable_i ? input_qual_time : '0;
      end
      mode_standby: begin
        resume_base = flash_sleeping_i ? cnt_w'(stby_resume_sleep) :
          cnt_w'(stby_resume_fast);
        resume_extra = qual_enable_i ? r.wake_cnt : '0;
      end
      default: begin
        resume_base = flash_sleeping_i ? cnt_w'(halt_resume_sleep) :
          cnt_w'(halt_resume_fast);
        resume_extra = '0;
      end
    endcase
  end
  assign resume_len = resume_base + resume_extra;
  always_comb begin
    next_r = r;
    next_r.nmi_sync = {r.nmi_sync[0], nonmaskable_wake_pin_n_i};
    next_r.rst_sync = {r.rst_sync[0], device_reset_pin_n_i};
    next_r.resume = 1'b0;
    next_r.service = 1'b0;
    case (r.st)
      st_run: begin
        if (idle_instr_i) begin
          next_r.mode = (low_power_mode_i == mode_rsvd) ? mode_halt : low_power_mode_i;
          next_r.cnt = '0;
          next_r.wake_cnt = '0;
          next_r.st = (low_power_mode_i == mode_idle) ? st_low : st_flush;
        end
      end
      st_flush: begin
        // clock held while the pipe drains
        next_r.cnt = r.cnt + cnt_w'(1);
        if (r.cnt == cnt_w'(flush_cycles - 1)) begin
          next_r.sys_en = 1'b0;
          next_r.core_en = 1'b0;
        end
        // external clock mirrors the system clock except on halt entry
        if (r.mode != mode_halt && r.cnt == cnt_w'(flush_cycles - 1)) begin
          next_r.xclk_en = 1'b0;
          next_r.cnt = '0;
          next_r.st = st_low;
        end
        if (r.mode == mode_halt && r.cnt == cnt_w'(halt_flush_cycles - 1)) begin
          next_r.xclk_en = 1'b0;
          next_r.cnt = '0;
          next_r.st = st_low;
        end
      end
      st_low: begin
        if (r.mode == mode_halt) begin
          next_r.xclk_en = 1'b0;
          next_r.osc = 1'b0;
          next_r.pll = 1'b0;
          if (nmi_q || rst_q) begin
            next_r.osc = 1'b1;
            next_r.st = st_osc;
          end
        end else begin
          if (nmi_act || rst_act) begin
            next_r.wake_cnt = r.wake_cnt + cnt_w'(1);
          end
          if (wake_any) begin
            next_r.sys_en = 1'b1;
            next_r.core_en = 1'b1;
            next_r.xclk_en = 1'b1;
            next_r.cnt = '0;
            next_r.st = st_resume;
          end
        end
      end
      st_osc: begin
        if (!nmi_act) begin
          next_r.pll = 1'b1;
          next_r.cnt = '0;
          next_r.st = st_lock;
        end
      end
      st_lock: begin
        next_r.cnt = r.cnt + cnt_w'(1);
        if (r.cnt == cnt_w'(pll_lock_len - 1)) begin
          next_r.sys_en = 1'b1;
          next_r.core_en = 1'b1;
          next_r.xclk_en = 1'b1;
          next_r.cnt = '0;
          next_r.st = st_resume;
        end
      end
      default: begin
        // st_resume: latency to the instruction after idle
        next_r.cnt = r.cnt + cnt_w'(1);
        if (r.cnt + cnt_w'(1) >= resume_len) begin
          next_r.resume = 1'b1;
          next_r.service = wake_int_enable_i;
          next_r.st = st_run;
        end
      end
    endcase
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '{
        nmi_sync: 2'b11,
        rst_sync: 2'b11,
        st: st_run,
        mode: mode_idle,
        cnt: '0,
        wake_cnt: '0,
        sys_en: 1'b1,
        xclk_en: 1'b1,
        core_en: 1'b1,
        osc: 1'b1,
        pll: 1'b1,
        resume: 1'b0,
        service: 1'b0
      };
    end else begin
      r <= next_r;
    end
  end
  assign system_clock_en_o = r.sys_en;
  assign external_clock_out_en_o = r.xclk_en;
  assign core_clock_input_en_o = r.core_en;
  assign osc_en_o = r.osc;
  assign pll_en_o = r.pll;
  assign resume_o = r.resume;
  assign wake_int_service_o = r.service;
  assign active_mode_o = r.mode;
endmodule // lpm_wakeup_sequencer

// ==== test/lpm_seq_monitor.sv ====
// checker: timing relations at the sequencer ports
// assumes binding onto lpm_wakeup_sequencer, one clock domain
`timescale 1ns/1ns
module lpm_seq_monitor (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // watched ports
  input wire logic idle_instr_i,
  input wire lpm_seq_pkg::lpm_mode_e low_power_mode_i,
  input wire logic wake_int_enable_i,
  input wire logic system_clock_en_o,
  input wire logic external_clock_out_en_o,
  input wire logic core_clock_input_en_o,
  input wire logic osc_en_o,
  input wire logic pll_en_o,
  input wire logic resume_o,
  input wire logic wake_int_service_o,
  input wire lpm_seq_pkg::lpm_mode_e active_mode_o
);
  import lpm_seq_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // halt exit: cycles since the core clock came back
  logic cck_prev;
  logic in_exit;
  logic [11:0] exit_cnt;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cck_prev <= 1'b1;
      in_exit <= 1'b0;
      exit_cnt <= 12'h000;
    end else begin
      cck_prev <= core_clock_input_en_o;
      if (core_clock_input_en_o && !cck_prev && active_mode_o == mode_halt) begin
        in_exit <= 1'b1;
        exit_cnt <= 12'h000;
      end else if (in_exit) begin
        exit_cnt <= exit_cnt + 12'h001;
        if (resume_o) begin
          in_exit <= 1'b0;
        end
      end
    end
  end
  resume_pulse_a: assert property (resume_o |=> !resume_o)
    else $error("resume wider than one cycle");
  service_pair_a: assert property (wake_int_service_o |-> resume_o && wake_int_enable_i)
    else $error("service without resume or enable");
  flush_hold_a: assert property ($fell(system_clock_en_o) |-> $past(system_clock_en_o, 31))
    else $error("system clock gated too early");
  xclk_late_a: assert property ($fell(external_clock_out_en_o) |-> !system_clock_en_o)
    else $error("external clock stopped before system clock");
  halt_dark_a: assert property (!osc_en_o |-> !pll_en_o && !core_clock_input_en_o)
    else $error("clock alive with oscillator off");
  osc_first_a: assert property ($rose(pll_en_o) |-> osc_en_o && !core_clock_input_en_o)
    else $error("pll started without oscillator");
  lock_wait_a: assert property ($rose(pll_en_o) |=> !core_clock_input_en_o [*8])
    else $error("core clock before lock time");
  halt_resume_a: assert property (in_exit && resume_o
    |-> exit_cnt >= 12'(halt_resume_fast - 1))
    else $error("halt resume too soon");
  halt_bound_a: assert property (in_exit
    |-> exit_cnt <= 12'(halt_resume_sleep - 1))
    else $error("halt resume overdue");
  idle_entry_a: assert property (idle_instr_i && low_power_mode_i == mode_idle
    && system_clock_en_o |=> !resume_o [*8])
    else $error("idle resume too soon");
endmodule // lpm_seq_monitor
bind lpm_wakeup_sequencer lpm_seq_monitor mon (.*);

// ==== test/wake_source.sv ====
// wake source model: holds the active-low wake pin for a set count
// assumes go_i is a one-cycle request from the bench
`timescale 1ns/1ns
module wake_source (
  // clock
  input wire logic core_clk_i,
  // request
  input wire logic go_i,
  input wire logic [15:0] hold_len_i,
  // pin
  output logic pin_n_o
);
  int left = 0;
  assign pin_n_o = (left == 0);
  always @(negedge core_clk_i) begin
    if (go_i) left <= hold_len_i;
    else if (left > 0) left <= left - 1;
  end
endmodule // wake_source

// ==== test/testbench.sv ====
// bench: runs idle, standby and halt entries and wakes, checks latencies
// assumes pll_lock_len shortened to 16
`timescale 1ns/1ns
module testbench;
  import lpm_seq_pkg::*;
  logic core_clk_i = 0, rst_n_i = 0, idle_i = 0, sleep = 0, qen = 0, ien = 0;
  logic eint = 0, wdog = 0, nmi_n, go = 0, rgo = 0, rst_pin_n, res, svc, sck, xck, cck, osc, pll;
  lpm_mode_e mode = mode_idle, amode;
  logic [7:0] qp = 8'h00, lfsr = 8'h3e;
  logic [5:0] qs = 6'h00;
  logic [15:0] len = 16'h0002;
  int err_total = 0, tests_run = 0, cyc = 0, lat, exp;
  always #2 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end
  lpm_wakeup_sequencer #(.pll_lock_len(16)) DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .idle_instr_i(idle_i), .low_power_mode_i(mode), .flash_sleeping_i(sleep),
    .qual_sample_period_i(qp), .standby_wake_qual_count_i(qs), .qual_enable_i(qen),
    .wake_int_enable_i(ien), .enabled_int_i(eint), .watchdog_wake_interrupt_i(wdog),
    .nonmaskable_wake_pin_n_i(nmi_n), .device_reset_pin_n_i(rst_pin_n),
    .system_clock_en_o(sck), .external_clock_out_en_o(xck), .core_clock_input_en_o(cck),
    .osc_en_o(osc), .pll_en_o(pll), .resume_o(res), .wake_int_service_o(svc),
    .active_mode_o(amode));
  wake_source far (.core_clk_i(core_clk_i), .go_i(go), .hold_len_i(len), .pin_n_o(nmi_n));
  wake_source far_rst (.core_clk_i(core_clk_i), .go_i(rgo), .hold_len_i(len),
    .pin_n_o(rst_pin_n));
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction
  task automatic check(input logic seen, input logic want);
    tests_run++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] %0t mismatch seen %b expected %b", $time, seen, want);
    end
  endtask
  task automatic run(input lpm_mode_e m, input int src, input logic slp);
    @(negedge core_clk_i);
    mode = m;
    sleep = slp;
    qp = rnd() & 8'h03;
    qs = 6'(rnd() & 8'h0f);
    qen = lfsr[0];
    ien = lfsr[1];
    exp = (m == mode_idle) ? (slp ? 1050 : 8) + (qen && src >= 2 ? 10 * qp : 0)
      : (m == mode_standby) ? (slp ? 1125 : 12) + (qen ? 2 + qs : 0) : (slp ? 1125 : 35);
    len = 16'((m == mode_halt) ? 8 : (m == mode_standby) ? 16 + qs : 4 + 10 * qp);
    idle_i = 1;
    @(negedge core_clk_i);
    idle_i = 0;
    repeat (50) @(negedge core_clk_i);
    if (m != mode_idle) check(sck | xck, 1'b0);
    if (m == mode_halt) check(osc | pll | cck, 1'b0);
    lat = 0;
    if (src == 0) eint = 1;
    else if (src == 1) wdog = 1;
    else if (src == 2) go <= 1;
    else rgo <= 1;
    for (int n = 1; n < 3000 && res !== 1'b1; n++) begin
      @(negedge core_clk_i);
      go <= 0;
      rgo <= 0;
      if (m != mode_halt || cck === 1'b1) lat++;
      if (m == mode_halt && src == 2 && n == 8) check(osc & ~pll, 1'b1);
    end
    check(res, 1'b1);
    check(sck & xck & cck, 1'b1);
    check(lat >= exp, 1'b1);
    check(svc, ien);
    check(amode == m, 1'b1);
    eint = 0;
    wdog = 0;
    $display("test mode %0d source %0d latency %0d done", m, src, lat);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge core_clk_i);
    rst_n_i = 1;
    for (int i = 0; i < 9; i++) run(lpm_mode_e'(i % 3), (i % 3 == 0) ? i / 3 : 2, i > 5);
    run(mode_idle, 3, 1'b0);
    run(mode_halt, 3, 1'b0);
    tally_and_finish();
  end
endmodule // testbench
